// *** sfp_pin_ctrl.sv ***
// Pin-function and lane control of a multi-I/O serial flash device.
// Assumes clk is the device clock and sck, cs_n and lanes come from a master.
module sfp_pin_ctrl #(
  parameter logic DEDICATED_RESET = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 reset_pin_n,
  input  wire logic [3:0]           lane_in,
  output logic      [3:0]           lane_out,
  output logic      [3:0]           lane_oe_n,
  input  wire logic                 quad_lane_enable,
  input  wire logic                 pause_or_reset_select,
  input  wire sfp_pkg::sfp_mode_t   io_mode,
  input  wire logic                 drive_out,
  input  wire logic                 status_write_disable,
  input  wire logic [7:0]           tx_word,
  output logic      [7:0]           rx_word,
  output logic                      rx_valid,
  output sfp_pkg::sfp_state_t       link_state,
  output logic                      write_protect_hold,
  output logic                      pause_active,
  output logic                      reset_active
);
  import sfp_pkg::*;

  sfp_pins_t     pins;
  sfp_pins_t     pins_raw;
  sfp_link_cfg_t cfg;
  sfp_link_cfg_t cfg_raw;
  logic [1:0]    hold_sync;
  sfp_state_t    next_state;
  logic          rx_tog_d;
  logic [7:0]    shift_rx_word;
  logic          shift_rx_toggle;

  // Pins that reach device-clock logic
  assign pins_raw.rx_toggle = shift_rx_toggle;
  assign pins_raw.cs_n      = cs_n;
  assign pins_raw.rst_n     = reset_pin_n;
  assign pins_raw.lane3     = lane_in[3];
  assign pins_raw.lane2     = lane_in[2];

  sfp_sync2 #(
    .W       (5),
    .RST_VAL (PINS_RST)
  ) u_pin_sync (
    .clk (clk),
    .rst (!resetn),
    .d   (pins_raw),
    .q   (pins)
  );

  // Pin function selection
  wire qe          = quad_lane_enable;
  wire sel_hold    = (pause_or_reset_select == PAUSE_SEL_HOLD);
  wire sel_reset   = (pause_or_reset_select == PAUSE_SEL_RESET);
  wire pause_fn    = !qe && (DEDICATED_RESET || sel_hold);
  wire shared_rst  = !DEDICATED_RESET && !qe && sel_reset;
  wire pin_reset   = DEDICATED_RESET ? !pins.rst_n :
                                       (shared_rst && !pins.lane3);
  wire selected    = !pins.cs_n;
  wire hold_now    = pause_fn && !pins.lane3 && selected;
  wire quad_req    = (io_mode == SFP_QUAD) || (io_mode == SFP_QCMD);

  // Quad lanes are only available with quad enable set
  wire sfp_mode_t eff_mode = (quad_req && !qe) ? SFP_SINGLE : io_mode;
  wire [3:0]      lane_use = sfp_lane_mask(cfg.mode);

  wire drive_ok   = drive_out && selected && !hold_now && !pin_reset && !reset_active
                    && (link_state == SFP_ACTIVE);
  wire [3:0] next_oe_n = drive_ok ? ~lane_use : LANES_OFF;
  wire wp_level   = status_write_disable && !qe && !pins.lane2;
  wire rx_evt     = pins.rx_toggle ^ rx_tog_d;

  // Link state: reset, deselect, pause and resume
  always_comb begin
    next_state = link_state;
    case (link_state)
      SFP_RESET: begin
        if (!pin_reset && pins.cs_n) begin
          next_state = SFP_IDLE;
        end
      end
      SFP_IDLE: begin
        if (selected) begin
          next_state = SFP_ACTIVE;
        end
      end
      SFP_ACTIVE: begin
        if (!selected) begin
          next_state = SFP_IDLE;
        end else if (hold_now) begin
          next_state = SFP_PAUSED;
        end
      end
      SFP_PAUSED: begin
        if (!selected) begin
          next_state = SFP_IDLE;
        end else if (!hold_now) begin
          next_state = SFP_ACTIVE;
        end
      end
      default: begin
        next_state = SFP_RESET;
      end
    endcase
    if (pin_reset) begin
      next_state = SFP_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_state <= SFP_RESET;
      reset_active <= 1'b1;
    end else begin
      link_state <= next_state;
      reset_active <= pin_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lane_oe_n          <= LANES_OFF;
      write_protect_hold <= 1'b0;
      pause_active       <= 1'b0;
    end else begin
      lane_oe_n          <= next_oe_n;
      write_protect_hold <= wp_level;
      pause_active       <= hold_now;
    end
  end

  // Config held steady here before it crosses to the serial clock
  assign cfg_raw.mode     = eff_mode;
  assign cfg_raw.pause_fn = pause_fn;
  assign cfg_raw.hold_n   = 1'b1;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg <= LINK_CFG_RST;
    end else begin
      cfg <= cfg_raw;
    end
  end

  // Received words: toggle event, word held stable by the shifter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_tog_d <= 1'b0;
      rx_valid <= 1'b0;
      rx_word  <= '0;
    end else begin
      rx_tog_d <= pins.rx_toggle;
      rx_valid <= rx_evt && !reset_active;
      if (rx_evt) begin
        rx_word <= shift_rx_word;
      end
    end
  end

  // Serial clock domain
  wire link_clear = cs_n || reset_active;

  // Hold pin into the serial clock; the serial clock stops between frames,
  // so the stages are preset by deselect and a frame never starts paused
  always_ff @(posedge sck or posedge link_clear) begin
    if (link_clear) begin
      hold_sync <= 2'b11;
    end else begin
      hold_sync <= {hold_sync[0], lane_in[3]};
    end
  end

  // Mode and hold function are quasi-static, registered and steady long before a frame
  wire link_pause = cfg.pause_fn && !hold_sync[1];

  sfp_lane_shift #(
    .W (WORD_W)
  ) u_shift (
    .sck        (sck),
    .clear      (link_clear),
    .hard_clear (reset_active),
    .pause      (link_pause),
    .mode       (cfg.mode),
    .lane_in    (lane_in),
    .tx_word    (tx_word),
    .rx_word    (shift_rx_word),
    .rx_toggle  (shift_rx_toggle),
    .lane_out   (lane_out)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_reset_floats_all: assert property (
    pin_reset |=> (lane_oe_n == LANES_OFF) && (link_state == SFP_RESET))
    else $error("reset pin did not float all lanes");

  a_hold_floats_out: assert property (
    hold_now |=> lane_oe_n[1] && lane_oe_n[0])
    else $error("output driven during hold");

  a_deselect_floats: assert property (
    pins.cs_n |=> (lane_oe_n == LANES_OFF) && (link_state != SFP_ACTIVE))
    else $error("lanes driven while deselected");

  a_qe_no_pause: assert property (
    (qe && !pins.lane3 && selected && !pin_reset && link_state == SFP_PAUSED)
      |=> link_state == SFP_ACTIVE)
    else $error("lane3 acted as hold with quad enable");

  a_ded_hold_sel: assert property (
    (DEDICATED_RESET && !qe && sel_reset && !pins.lane3 && selected
      && link_state == SFP_ACTIVE && pins.rst_n) |=> link_state == SFP_PAUSED)
    else $error("dedicated variant ignored hold");

  a_hold_pauses: assert property (
    (link_state == SFP_ACTIVE && hold_now && !pin_reset) |=> link_state == SFP_PAUSED)
    else $error("hold did not pause");

  a_hold_resumes: assert property (
    (link_state == SFP_PAUSED && selected && !hold_now && !pin_reset)
      |=> link_state == SFP_ACTIVE)
    else $error("release did not resume");

  a_shared_reset_sel: assert property (
    (shared_rst && !pins.lane3) |=> reset_active && (link_state == SFP_RESET))
    else $error("shared pin reset not taken");

  a_reset_release: assert property (
    (link_state == SFP_RESET && !pin_reset && pins.cs_n) |=> link_state == SFP_IDLE)
    else $error("device stayed in reset");

  a_quad_needs_qe: assert property (
    (quad_req && !qe) |=> cfg.mode == SFP_SINGLE)
    else $error("quad lanes used without quad enable");

  a_single_one_lane: assert property (
    (cfg.mode == SFP_SINGLE) |=> lane_oe_n[0] && lane_oe_n[2] && lane_oe_n[3])
    else $error("single mode drove an input lane");

  a_wp_off_quad: assert property (
    qe |=> !write_protect_hold)
    else $error("write protect active in quad");

  c_pause_resume: cover property (
    link_state == SFP_ACTIVE ##1 link_state == SFP_PAUSED [*2] ##1 link_state == SFP_ACTIVE);

  c_pin_reset: cover property (reset_active ##1 link_state == SFP_IDLE);

  c_rx_word: cover property (rx_valid);

  c_quad_drive: cover property (lane_oe_n == 4'h0);

endmodule

// *** sfp_pkg.sv ***
// Shared types and constants for the serial flash pin-function block.
// Assumes a device clock domain plus the serial clock driven by the master.
package sfp_pkg;

  localparam int WORD_W    = 8;
  localparam int LANES     = 4;
  localparam int BIT_CNT_W = 4;

  typedef enum logic [3:0] {
    SFP_SINGLE = 4'h1,
    SFP_DUAL   = 4'h2,
    SFP_QUAD   = 4'h4,
    SFP_QCMD   = 4'h8
  } sfp_mode_t;

  typedef enum logic [3:0] {
    SFP_IDLE   = 4'h1,
    SFP_ACTIVE = 4'h2,
    SFP_PAUSED = 4'h4,
    SFP_RESET  = 4'h8
  } sfp_state_t;

  // Lanes the device may drive in each mode
  localparam logic [3:0] LANES_SINGLE = 4'h2;
  localparam logic [3:0] LANES_DUAL   = 4'h3;
  localparam logic [3:0] LANES_QUAD   = 4'hf;
  localparam logic [3:0] LANES_OFF    = 4'hf;

  localparam logic PAUSE_SEL_HOLD  = 1'b0;
  localparam logic PAUSE_SEL_RESET = 1'b1;

  typedef struct packed {
    logic rx_toggle;
    logic cs_n;
    logic rst_n;
    logic lane3;
    logic lane2;
  } sfp_pins_t;

  localparam logic [4:0] PINS_RST = 5'h0f;

  typedef struct packed {
    sfp_mode_t mode;
    logic      pause_fn;
    logic      hold_n;
  } sfp_link_cfg_t;

  localparam logic [5:0] LINK_CFG_RST = 6'h07;

  function automatic logic [BIT_CNT_W-1:0] sfp_step(input sfp_mode_t m);
    case (m)
      SFP_DUAL:           sfp_step = 4'h2;
      SFP_QUAD, SFP_QCMD: sfp_step = 4'h4;
      default:            sfp_step = 4'h1;
    endcase
  endfunction

  function automatic logic [3:0] sfp_lane_mask(input sfp_mode_t m);
    case (m)
      SFP_DUAL:           sfp_lane_mask = LANES_DUAL;
      SFP_QUAD, SFP_QCMD: sfp_lane_mask = LANES_QUAD;
      default:            sfp_lane_mask = LANES_SINGLE;
    endcase
  endfunction

endpackage

// *** sfp_sync2.sv ***
// Two-stage synchroniser for a bundle of levels.
// Assumes each bit is a level that stays put for several destination clocks.
module sfp_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import sfp_pkg::*;

  logic [W-1:0] meta;

  // The first stage feeds the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// *** sfp_lane_shift.sv ***
// Serial-clock side lane shifter: samples lanes, launches output bits.
// Assumes clear ends every frame and config is steady within a frame.
module sfp_lane_shift #(
  parameter int W = sfp_pkg::WORD_W
) (
  input  wire logic              sck,
  input  wire logic              clear,
  input  wire logic              hard_clear,
  input  wire logic              pause,
  input  wire sfp_pkg::sfp_mode_t mode,
  input  wire logic [3:0]        lane_in,
  input  wire logic [W-1:0]      tx_word,
  output logic      [W-1:0]      rx_word,
  output logic                   rx_toggle,
  output logic      [3:0]        lane_out
);
  import sfp_pkg::*;

  localparam logic [BIT_CNT_W-1:0] CNT_FULL = BIT_CNT_W'(W);

  logic [W-1:0]           shift_in;
  logic [BIT_CNT_W-1:0]   cnt;
  logic [W-1:0]           out_word;

  wire                    is_dual   = (mode == SFP_DUAL);
  wire                    is_quad   = (mode == SFP_QUAD) || (mode == SFP_QCMD);
  wire [BIT_CNT_W-1:0]    step      = sfp_step(mode);
  wire [BIT_CNT_W-1:0]    next_cnt  = cnt + step;
  wire                    byte_done = (next_cnt == CNT_FULL);
  wire [W-1:0]            next_in   = is_quad ? {shift_in[W-5:0], lane_in} :
                                      is_dual ? {shift_in[W-3:0], lane_in[1:0]} :
                                                {shift_in[W-2:0], lane_in[0]};
  wire [W-1:0]            next_out  = (cnt == '0) ? tx_word : (out_word << step);
  wire [3:0]              next_lane = is_quad ? next_out[W-1:W-4] :
                                      is_dual ? {2'h0, next_out[W-1:W-2]} :
                                                {2'h0, next_out[W-1], 1'b0};

  // Input bits are taken on the rising edge; a pause freezes the count
  always_ff @(posedge sck or posedge clear) begin
    if (clear) begin
      cnt      <= '0;
      shift_in <= '0;
    end else if (!pause) begin
      shift_in <= next_in;
      cnt      <= byte_done ? '0 : next_cnt;
    end
  end

  // Kept across frames so the far domain never sees a false toggle
  always_ff @(posedge sck or posedge hard_clear) begin
    if (hard_clear) begin
      rx_word   <= '0;
      rx_toggle <= 1'b0;
    end else if (!pause && !clear && byte_done) begin
      rx_word   <= next_in;
      rx_toggle <= ~rx_toggle;
    end
  end

  // Output bits launch on the falling edge in either clock mode
  always_ff @(negedge sck or posedge clear) begin
    if (clear) begin
      out_word <= '0;
      lane_out <= '0;
    end else if (!pause) begin
      out_word <= next_out;
      lane_out <= next_lane;
    end
  end

endmodule

// *** sfp_master_model.sv ***
// Serial master model driving the link of the pin-function block.
// Assumes undriven lanes are pulled up by the bench wiring.
module sfp_master_model (
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      m_val,
  output logic [3:0]      m_oe,
  input  wire logic [3:0] lane_obs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode3;
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    m_val = 4'hf;
    m_oe  = 4'h0;
    mode3 = 1'b0;
  end
  // Clock idles at the mode's level; select falls only after that
  task automatic start(input logic m3);
    mode3 = m3;
    sck   = m3;
    #20;
    cs_n  = 1'b0;
    #20;
  endtask
  task automatic stop;
    sck  = mode3;
    #8;
    cs_n = 1'b1;
    m_oe = 4'h0;
    #40;
  endtask
  task automatic pin(input int i, input logic oe, input logic v);
    m_oe[i]  = oe;
    m_val[i] = v;
  endtask
  // Top bits of sh go out first, highest lane carrying the older bit
  task automatic shift(input logic [7:0] d, input int nb, input int per, output logic [7:0] rd);
    logic [7:0] sh;
    logic [3:0] mask;
    sh   = d;
    rd   = 8'h00;
    mask = (per == 1) ? 4'h1 : (per == 2) ? 4'h3 : 4'hf;
    m_oe = m_oe | mask;
    for (int i = 0; i < nb; i += per) begin
      sck   = 1'b0;
      #8;
      m_val = (m_val & ~mask) | (4'(sh[7:4] >> (4 - per)) & mask);
      sh    = sh << per;
      #8;
      sck   = 1'b1;
      rd    = {rd[6:0], lane_obs[1]};
      #16;
    end
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the serial flash pin-function block.
// Assumes the shared hold/reset variant and a behavioural master on the link.
module tb_top;
  import sfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, resetn, reset_pin_n, qe, sel, drive_out, swd, rx_valid, wph, pause_active, reset_active;
  logic       sck, cs_n;
  logic [3:0] m_val, m_oe, lane_in, lane_out, lane_oe_n;
  logic [7:0] tx_word, rx_word, rd;
  sfp_mode_t  io_mode;
  sfp_state_t link_state;
  int         err_count, samples_checked;
  // Device wins where it drives, master next, pull-up otherwise
  assign lane_in = (~lane_oe_n & lane_out) | (lane_oe_n & ((m_oe & m_val) | ~m_oe));
  sfp_pin_ctrl #(.DEDICATED_RESET(1'b0)) dut (
    .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .reset_pin_n(reset_pin_n),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe_n(lane_oe_n), .quad_lane_enable(qe),
    .pause_or_reset_select(sel), .io_mode(io_mode), .drive_out(drive_out),
    .status_write_disable(swd), .tx_word(tx_word), .rx_word(rx_word), .rx_valid(rx_valid),
    .link_state(link_state), .write_protect_hold(wph), .pause_active(pause_active),
    .reset_active(reset_active));
  sfp_master_model m (.sck(sck), .cs_n(cs_n), .m_val(m_val), .m_oe(m_oe), .lane_obs(lane_out));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cfg(input sfp_mode_t md, input logic q, input logic s, input logic d);
    @(negedge clk);
    io_mode   = md;
    qe        = q;
    sel       = s;
    drive_out = d;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_rx(input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check({7'h0, rx_valid}, 8'h01);
    check(rx_word, exp);
    @(negedge clk);
  endtask
  task automatic t_reset;
    check({4'h0, link_state}, {4'h0, SFP_RESET});
    check({4'h0, lane_oe_n}, 8'h0f);
    resetn = 1'b1;
    settle(6);
    check({4'h0, link_state}, {4'h0, SFP_IDLE});
    check({7'h0, reset_active}, 8'h00);
  endtask
  task automatic t_single(input logic m3, input logic [7:0] d);
    cfg(SFP_SINGLE, 1'b0, 1'b0, 1'b0);
    m.start(m3);
    m.shift(d, 8, 1, rd);
    wait_rx(d);
    m.stop;
  endtask
  task automatic t_multi(input sfp_mode_t md, input int per, input logic [7:0] d);
    cfg(md, 1'b1, 1'b0, 1'b0);
    m.start(1'b0);
    m.shift(d, 8, per, rd);
    wait_rx(d);
    check({7'h0, pause_active}, 8'h00);
    m.stop;
  endtask
  task automatic t_read;
    cfg(SFP_SINGLE, 1'b0, 1'b0, 1'b1);
    tx_word = 8'h96;
    m.start(1'b0);
    m.shift(8'hc3, 8, 1, rd);
    wait_rx(8'hc3);
    check({7'h0, lane_oe_n[1]}, 8'h00);
    m.shift(8'h00, 8, 1, rd);
    check(rd, 8'h96);
    m.stop;
    settle(6);
    check({4'h0, lane_oe_n}, 8'h0f);
  endtask
  // Partial byte b4: bits frozen during hold must not enter the word
  task automatic t_hold;
    cfg(SFP_SINGLE, 1'b0, 1'b0, 1'b1);
    m.start(1'b0);
    m.shift(8'hb4, 4, 1, rd);
    m.pin(3, 1'b1, 1'b0);
    m.shift(8'h40, 2, 1, rd);
    m.shift(8'he0, 3, 1, rd);
    settle(6);
    check({7'h0, pause_active}, 8'h01);
    check({7'h0, lane_oe_n[1]}, 8'h01);
    m.pin(3, 1'b0, 1'b1);
    m.shift(8'hc0, 2, 1, rd);
    m.shift(8'h00, 2, 1, rd);
    wait_rx(8'hb4);
    check({7'h0, pause_active}, 8'h00);
    m.stop;
  endtask
  // Pin reset only with the link idle, so no internal write is cut
  task automatic t_pinreset;
    cfg(SFP_SINGLE, 1'b0, 1'b0, 1'b0);
    m.pin(3, 1'b1, 1'b0);
    settle(6);
    check({7'h0, reset_active}, 8'h00);
    cfg(SFP_SINGLE, 1'b0, 1'b1, 1'b0);
    settle(6);
    check({7'h0, reset_active}, 8'h01);
    check({4'h0, link_state}, {4'h0, SFP_RESET});
    check({4'h0, lane_oe_n}, 8'h0f);
    m.pin(3, 1'b0, 1'b1);
    settle(8);
    check({4'h0, link_state}, {4'h0, SFP_IDLE});
  endtask
  task automatic t_wp;
    @(negedge clk);
    swd = 1'b1;
    cfg(SFP_SINGLE, 1'b0, 1'b0, 1'b0);
    m.pin(2, 1'b1, 1'b0);
    settle(6);
    check({7'h0, wph}, 8'h01);
    cfg(SFP_SINGLE, 1'b1, 1'b0, 1'b0);
    settle(6);
    check({7'h0, wph}, 8'h00);
    m.pin(2, 1'b0, 1'b1);
  endtask
  initial begin
    resetn          = 1'b0;
    reset_pin_n     = 1'b1;
    qe              = 1'b0;
    sel             = 1'b0;
    drive_out       = 1'b0;
    swd             = 1'b0;
    io_mode         = SFP_SINGLE;
    tx_word         = 8'h00;
    err_count       = 0;
    samples_checked = 0;
    settle(5);
    t_reset;
    t_single(1'b0, 8'ha5);
    t_single(1'b1, 8'h3c);
    t_multi(SFP_DUAL, 2, 8'h6d);
    t_multi(SFP_QUAD, 4, 8'h5a);
    t_multi(SFP_QCMD, 4, 8'h1e);
    t_read;
    t_hold;
    t_pinreset;
    t_wp;
    complete_run;
  end
  initial begin
    #200000;
    err_count++;
    complete_run;
  end
endmodule
